// ==== rtl/sbpfs_defines.svh ====
// register offsets, field positions, reset values and code points of the six-pin port
`ifndef SBPFS_DEFINES_SVH
`define SBPFS_DEFINES_SVH

`define SBPFS_NPINS          6
`define SBPFS_OFS_DATA       8'h00
`define SBPFS_OFS_DIR        8'h04
`define SBPFS_OFS_DRV_LOW    8'h08
`define SBPFS_OFS_DRV_HIGH   8'h0C
`define SBPFS_OFS_FUNC       8'h10
`define SBPFS_FUNC_HI_POS    8
`define SBPFS_RST_DATA       6'h00
`define SBPFS_RST_DIR        6'h00
`define SBPFS_RST_DRV        6'h00
`define SBPFS_RST_FUNC       16'h0000
`define SBPFS_FN_GPIO        2'h0
`define SBPFS_FN_ALT1        2'h1
`define SBPFS_FN_ALT2        2'h2
`define SBPFS_FN_ALT3        2'h3
`define SBPFS_DRV_HIZ        2'h0
`define SBPFS_DRV_POD        2'h1
`define SBPFS_DRV_NOD        2'h2
`define SBPFS_DRV_CMOS       2'h3
`define SBPFS_DIR_OUT        1'h0
`define SBPFS_DIR_IN         1'h1

`endif

// ==== rtl/sbpfs_pkg.sv ====
// types shared by the six-pin port design
package sbpfs_pkg;
  typedef logic [1:0] sbpfs_code_t;
  typedef enum logic [1:0] {
    SBPFS_PULL_NONE,
    SBPFS_PULL_DOWN,
    SBPFS_PULL_UP
  } sbpfs_pull_e;
endpackage

// ==== rtl/sbpfs_pin_drive.sv ====
// one pin's drive and pull stage
module sbpfs_pin_drive
  import sbpfs_pkg::*;
(
  // configuration
  input  wire logic        dir_i,
  input  wire sbpfs_code_t drv_i,
  input  wire logic        frozen_i,
  // value to put out
  input  wire logic        val_i,
  // pad side
  output logic             pad_o,
  output logic             pad_oe_o,
  output sbpfs_pull_e      pull_o
);
  `include "sbpfs_defines.svh"

  wire is_out = (dir_i == `SBPFS_DIR_OUT);
  // a frozen pin drops its data: open drain high side floats, low side pulls low
  wire eff_val = frozen_i ? 1'b0 : val_i;

  assign pad_o    = is_out & (drv_i == `SBPFS_DRV_CMOS | drv_i == `SBPFS_DRV_POD) & eff_val;
  assign pad_oe_o = is_out & (
                      (drv_i == `SBPFS_DRV_CMOS) |
                      (drv_i == `SBPFS_DRV_POD & eff_val) |
                      (drv_i == `SBPFS_DRV_NOD & ~eff_val));

  assign pull_o = (!is_out && drv_i == `SBPFS_DRV_POD) ? SBPFS_PULL_DOWN :
                  (!is_out && drv_i == `SBPFS_DRV_NOD) ? SBPFS_PULL_UP : SBPFS_PULL_NONE;
endmodule

// ==== rtl/sbpfs_port.sv ====
// six-pin port with direction, drive, data and function select over wishbone
`include "sbpfs_defines.svh"

module sbpfs_port
  import sbpfs_pkg::*;
(
  // system
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  // wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  output logic             ERR_O,
  // pads
  input  wire logic [5:0]  PAD_I,
  output logic      [5:0]  PAD_O,
  output logic      [5:0]  PAD_OE_O,
  output sbpfs_pull_e      PAD_PULL_O [6],
  // synchronised pin levels for external interrupt and analog owners
  output logic      [5:0]  PIN_LEVEL_O,
  // rc oscillation converter
  input  wire logic        CONV_WAVE_IN_OUT_I,
  input  wire logic        CONV_WAVE_IN_OE_I,
  output logic             CONV_WAVE_IN_O,
  input  wire logic        CONV_REF_CAP_I,
  input  wire logic        CONV_REF_CAP_OE_I,
  output logic             CONV_REF_CAP_O,
  input  wire logic        CONV_SENSOR_I,
  input  wire logic        CONV_SENSOR_OE_I,
  output logic             CONV_SENSOR_O,
  input  wire logic        CONV_REF_RES_I,
  input  wire logic        CONV_REF_RES_OE_I,
  output logic             CONV_REF_RES_O,
  input  wire logic        CONV_MEASURE_I,
  input  wire logic        CONV_MEASURE_OE_I,
  output logic             CONV_MEASURE_O,
  input  wire logic        CONV_OSC_MONITOR_I,
  // clocked serial unit
  input  wire logic        SER_DATA_OUT_I,
  output logic             SER_DATA_IN_O,
  input  wire logic        SER_CLOCK_I,
  input  wire logic        SER_CLOCK_OE_I,
  output logic             SER_CLOCK_O,
  // async serial unit
  output logic             ASYNC_RECEIVE_O,
  input  wire logic        ASYNC_TRANSMIT_I,
  // function timer unit
  input  wire logic        TIMER_OUT_ZERO_I,
  input  wire logic        TIMER_OUT_ONE_I
);

  localparam int NPINS = `SBPFS_NPINS;

  // registers
  logic [5:0]  data_ff;
  logic [5:0]  dir_ff;
  logic [5:0]  drv_lo_ff;
  logic [5:0]  drv_hi_ff;
  logic [15:0] func_ff;
  logic        ack_ff;
  logic        err_ff;
  logic [31:0] rdat_ff;
  logic [5:0]  pad_s1_ff;
  logic [5:0]  pad_s2_ff;

  // bus decode
  wire req      = CYC_I & STB_I & ~ack_ff & ~err_ff;
  wire hit_data = (ADR_I == `SBPFS_OFS_DATA);
  wire hit_dir  = (ADR_I == `SBPFS_OFS_DIR);
  wire hit_lo   = (ADR_I == `SBPFS_OFS_DRV_LOW);
  wire hit_hi   = (ADR_I == `SBPFS_OFS_DRV_HIGH);
  wire hit_func = (ADR_I == `SBPFS_OFS_FUNC);
  wire hit_any  = hit_data | hit_dir | hit_lo | hit_hi | hit_func;
  wire wr       = req & WE_I & hit_any;
  wire wr_b0    = wr & SEL_I[0];
  wire wr_b1    = wr & SEL_I[1];

  // per-pin decode
  logic [1:0] fn [6];
  logic [1:0] drv [6];
  logic [5:0] frozen;
  logic [5:0] alt_val;
  logic [5:0] alt_oe;
  logic [5:0] alt_used;

  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      fn[i]  = {func_ff[`SBPFS_FUNC_HI_POS + i], func_ff[i]};
      drv[i] = {drv_hi_ff[i], drv_lo_ff[i]};
    end
  end

  // prohibited codes only exist on pins 3 to 5
  assign frozen[0] = 1'b0;
  assign frozen[1] = 1'b0;
  assign frozen[2] = 1'b0;
  assign frozen[3] = (fn[3] == `SBPFS_FN_ALT2);
  assign frozen[4] = fn[4][1];
  assign frozen[5] = fn[5][1];

  // alternate function routing
  always_comb begin
    alt_val  = 6'h00;
    alt_oe   = 6'h00;
    alt_used = 6'h00;
    unique case (fn[0])
      `SBPFS_FN_ALT1: begin
        alt_val[0] = CONV_WAVE_IN_OUT_I;
        alt_oe[0]  = CONV_WAVE_IN_OE_I;
        alt_used[0] = 1'b1;
      end
      `SBPFS_FN_ALT2: begin
        alt_val[0] = SER_DATA_OUT_I;
        alt_oe[0]  = 1'b1;
        alt_used[0] = 1'b1;
      end
      `SBPFS_FN_ALT3: begin
        alt_oe[0]   = 1'b0;
        alt_used[0] = 1'b1;
      end
      `SBPFS_FN_GPIO: begin
        alt_used[0] = 1'b0;
      end
    endcase
    unique case (fn[1])
      `SBPFS_FN_ALT1: begin
        alt_val[1] = CONV_REF_CAP_I;
        alt_oe[1]  = CONV_REF_CAP_OE_I;
        alt_used[1] = 1'b1;
      end
      `SBPFS_FN_ALT2: begin
        alt_used[1] = 1'b1;
      end
      `SBPFS_FN_ALT3: begin
        alt_val[1] = ASYNC_TRANSMIT_I;
        alt_oe[1]  = 1'b1;
        alt_used[1] = 1'b1;
      end
      `SBPFS_FN_GPIO: begin
        alt_used[1] = 1'b0;
      end
    endcase
    unique case (fn[2])
      `SBPFS_FN_ALT1: begin
        alt_val[2] = CONV_SENSOR_I;
        alt_oe[2]  = CONV_SENSOR_OE_I;
        alt_used[2] = 1'b1;
      end
      `SBPFS_FN_ALT2: begin
        alt_val[2] = SER_CLOCK_I;
        alt_oe[2]  = SER_CLOCK_OE_I;
        alt_used[2] = 1'b1;
      end
      `SBPFS_FN_ALT3: begin
        alt_val[2] = TIMER_OUT_ZERO_I;
        alt_oe[2]  = 1'b1;
        alt_used[2] = 1'b1;
      end
      `SBPFS_FN_GPIO: begin
        alt_used[2] = 1'b0;
      end
    endcase
    unique case (fn[3])
      `SBPFS_FN_ALT1: begin
        alt_val[3] = CONV_REF_RES_I;
        alt_oe[3]  = CONV_REF_RES_OE_I;
        alt_used[3] = 1'b1;
      end
      `SBPFS_FN_ALT3: begin
        alt_val[3] = TIMER_OUT_ONE_I;
        alt_oe[3]  = 1'b1;
        alt_used[3] = 1'b1;
      end
      default: begin
        alt_used[3] = 1'b0;
      end
    endcase
    if (fn[4] == `SBPFS_FN_ALT1) begin
      alt_val[4]  = CONV_MEASURE_I;
      alt_oe[4]   = CONV_MEASURE_OE_I;
      alt_used[4] = 1'b1;
    end
    if (fn[5] == `SBPFS_FN_ALT1) begin
      alt_val[5]  = CONV_OSC_MONITOR_I;
      alt_oe[5]   = 1'b1;
      alt_used[5] = 1'b1;
    end
  end

  // peripheral inputs see the synchronised pad level only when routed
  assign CONV_WAVE_IN_O  = (fn[0] == `SBPFS_FN_ALT1) & pad_s2_ff[0];
  assign SER_DATA_IN_O   = (fn[1] == `SBPFS_FN_ALT2) & pad_s2_ff[1];
  assign CONV_REF_CAP_O  = (fn[1] == `SBPFS_FN_ALT1) & pad_s2_ff[1];
  assign CONV_SENSOR_O   = (fn[2] == `SBPFS_FN_ALT1) & pad_s2_ff[2];
  assign SER_CLOCK_O     = (fn[2] == `SBPFS_FN_ALT2) & pad_s2_ff[2];
  assign CONV_REF_RES_O  = (fn[3] == `SBPFS_FN_ALT1) & pad_s2_ff[3];
  assign CONV_MEASURE_O  = (fn[4] == `SBPFS_FN_ALT1) & pad_s2_ff[4];
  // idle level of an async line is high
  assign ASYNC_RECEIVE_O = (fn[0] == `SBPFS_FN_ALT3) ? pad_s2_ff[0] : 1'b1;
  assign PIN_LEVEL_O     = pad_s2_ff;

  // pad stages
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      logic pin_val;
      logic pin_oe;
      logic stage_val;
      logic stage_oe;
      sbpfs_pull_e stage_pull;
      assign pin_val = alt_used[g] ? alt_val[g] : data_ff[g];
      sbpfs_pin_drive u_drive (
        .dir_i    (dir_ff[g]),
        .drv_i    (drv[g]),
        .frozen_i (frozen[g]),
        .val_i    (pin_val),
        .pad_o    (stage_val),
        .pad_oe_o (stage_oe),
        .pull_o   (stage_pull)
      );
      // peripheral may release the pad on its own (bidirectional alternates)
      assign pin_oe      = stage_oe & (~alt_used[g] | alt_oe[g]);
      assign PAD_O[g]    = stage_val & pin_oe;
      assign PAD_OE_O[g] = pin_oe;
      assign PAD_PULL_O[g] = stage_pull;
    end
  endgenerate

  // read mux; input pins read the pad, output pins the latch
  wire [5:0] data_rd = (dir_ff & pad_s2_ff) | (~dir_ff & data_ff);
  wire [31:0] rd_word =
    hit_data ? {26'h0, data_rd} :
    hit_dir  ? {26'h0, dir_ff} :
    hit_lo   ? {26'h0, drv_lo_ff} :
    hit_hi   ? {26'h0, drv_hi_ff} :
    hit_func ? {16'h0, 2'h0, func_ff[13:8], 2'h0, func_ff[5:0]} : 32'h0;

  // pad synchroniser: two stages before any use
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pad_s1_ff <= 6'h00;
      pad_s2_ff <= 6'h00;
    end else begin
      pad_s1_ff <= PAD_I;
      pad_s2_ff <= pad_s1_ff;
    end
  end

  // bus handshake: one wait state, err on unmapped address
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ack_ff  <= 1'b0;
      err_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff  <= req & hit_any;
      err_ff  <= req & ~hit_any;
      rdat_ff <= (req & ~WE_I) ? rd_word : 32'h0000_0000;
    end
  end

  // configuration registers
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      data_ff   <= `SBPFS_RST_DATA;
      dir_ff    <= `SBPFS_RST_DIR;
      drv_lo_ff <= `SBPFS_RST_DRV;
      drv_hi_ff <= `SBPFS_RST_DRV;
      func_ff   <= `SBPFS_RST_FUNC;
    end else begin
      if (wr_b0 && hit_data) data_ff <= DAT_I[5:0];
      if (wr_b0 && hit_dir) dir_ff <= DAT_I[5:0];
      if (wr_b0 && hit_lo) drv_lo_ff <= DAT_I[5:0];
      if (wr_b0 && hit_hi) drv_hi_ff <= DAT_I[5:0];
      if (wr_b0 && hit_func) func_ff[5:0] <= DAT_I[5:0];
      if (wr_b1 && hit_func) func_ff[13:8] <= DAT_I[13:8];
    end
  end

  assign ACK_O = ack_ff;
  assign ERR_O = err_ff;
  assign DAT_O = rdat_ff;

endmodule

// ==== verif/sbpfs_port_chk.sv ====
// bus, pad and synchroniser checks bound to the six-pin port
module sbpfs_port_chk
  import sbpfs_pkg::*;
(
  // system
  input wire logic        CLK_I,
  input wire logic        RST_B_I,
  // bus
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        ACK_O,
  input wire logic        ERR_O,
  input wire logic [31:0] DAT_O,
  // pads and routed levels
  input wire logic [5:0]  PAD_I,
  input wire logic [5:0]  PAD_O,
  input wire logic [5:0]  PAD_OE_O,
  input wire sbpfs_pull_e PAD_PULL_O [6],
  input wire logic [5:0]  PIN_LEVEL_O,
  input wire logic        ASYNC_RECEIVE_O,
  input wire logic        SER_DATA_IN_O
);
  logic [1:0] age_ff;
  logic [5:0] pull_on;
  // synchroniser still holds reset values for two edges
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) age_ff <= 2'h0;
    else if (age_ff != 2'h3) age_ff <= age_ff + 2'h1;
  end
  always_comb begin
    for (int i = 0; i < 6; i++) pull_on[i] = PAD_PULL_O[i] != SBPFS_PULL_NONE;
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  sequence s_take;
    CYC_I && STB_I && !ACK_O && !ERR_O;
  endsequence
  sequence s_answer;
    (ACK_O ^ ERR_O) ##1 !(ACK_O || ERR_O);
  endsequence
  a_req_answered: assert property (s_take |=> s_answer)
    else $error("request not answered once in one cycle");
  a_dat_idle: assert property (!ACK_O |-> DAT_O == 32'h0)
    else $error("read data outside acknowledge");
  a_undriven_low: assert property ((PAD_O & ~PAD_OE_O) == 6'h00)
    else $error("pad value without enable");
  a_pull_input_only: assert property ((pull_on & PAD_OE_O) == 6'h00)
    else $error("pull on a driven pin");
  a_reset_quiet: assert property ($rose(RST_B_I) |-> PAD_OE_O == 6'h00 && pull_on == 6'h00)
    else $error("pins not released by reset");
  a_level_sync: assert property (age_ff == 2'h3 |-> PIN_LEVEL_O == $past(PAD_I, 2))
    else $error("pin level not two cycles late");
  a_async_level: assert property (!ASYNC_RECEIVE_O |-> !PIN_LEVEL_O[0])
    else $error("receive low while pin high");
  a_ser_in_level: assert property (SER_DATA_IN_O |-> PIN_LEVEL_O[1])
    else $error("serial input high while pin low");
endmodule

bind sbpfs_port sbpfs_port_chk u_chk (
  .CLK_I(CLK_I), .RST_B_I(RST_B_I), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
  .ERR_O(ERR_O), .DAT_O(DAT_O), .PAD_I(PAD_I), .PAD_O(PAD_O), .PAD_OE_O(PAD_OE_O),
  .PAD_PULL_O(PAD_PULL_O), .PIN_LEVEL_O(PIN_LEVEL_O), .ASYNC_RECEIVE_O(ASYNC_RECEIVE_O),
  .SER_DATA_IN_O(SER_DATA_IN_O)
);

// ==== verif/sbpfs_pad_model.sv ====
// external pins: port drive wins, then outside driver, then pull
module sbpfs_pad_model
  import sbpfs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic [5:0]  drv_i,
  input  wire logic [5:0]  oe_i,
  input  wire logic [5:0]  ext_en_i,
  input  wire logic [5:0]  ext_val_i,
  input  wire sbpfs_pull_e pull_i [6],
  output logic      [5:0]  pad_o
);
  logic tog_ff = 1'h0;
  // a floating pin must not look stable
  always @(posedge clk_i) tog_ff <= !tog_ff;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (oe_i[i]) pad_o[i] = drv_i[i];
      else if (ext_en_i[i]) pad_o[i] = ext_val_i[i];
      else if (pull_i[i] != SBPFS_PULL_NONE) pad_o[i] = pull_i[i] == SBPFS_PULL_UP;
      else pad_o[i] = tog_ff ^ i[0];
    end
  end
endmodule

// ==== verif/tb.sv ====
// self-checking bench for the six-pin port
`include "sbpfs_defines.svh"
module tb
  import sbpfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst_b = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, err, re, ar;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, dato, rq;
  logic [5:0] pad, po, poe, ee = 6'h00, ev = 6'h00, dat, dir, dl, dh, mk, lv, pm, plv;
  logic [15:0] fn;
  logic [16:0] per = 17'h0;
  sbpfs_pull_e pull [6];
  int num_errors = 0, n_compared = 0;
  always #10 clk = !clk;
  sbpfs_port dut (.CLK_I(clk), .RST_B_I(rst_b), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(4'h3), .DAT_I(wdat), .DAT_O(dato), .ACK_O(ack), .ERR_O(err),
    .PAD_I(pad), .PAD_O(po), .PAD_OE_O(poe), .PAD_PULL_O(pull), .PIN_LEVEL_O(plv),
    .CONV_WAVE_IN_OUT_I(per[0]), .CONV_WAVE_IN_OE_I(per[1]), .CONV_WAVE_IN_O(),
    .CONV_REF_CAP_I(per[2]), .CONV_REF_CAP_OE_I(per[3]), .CONV_REF_CAP_O(),
    .CONV_SENSOR_I(per[4]), .CONV_SENSOR_OE_I(per[5]), .CONV_SENSOR_O(),
    .CONV_REF_RES_I(per[6]), .CONV_REF_RES_OE_I(per[7]), .CONV_REF_RES_O(),
    .CONV_MEASURE_I(per[8]), .CONV_MEASURE_OE_I(per[9]), .CONV_MEASURE_O(),
    .CONV_OSC_MONITOR_I(per[10]), .SER_DATA_OUT_I(per[11]), .SER_DATA_IN_O(),
    .SER_CLOCK_I(per[12]), .SER_CLOCK_OE_I(per[13]), .SER_CLOCK_O(), .ASYNC_RECEIVE_O(ar),
    .ASYNC_TRANSMIT_I(per[14]), .TIMER_OUT_ZERO_I(per[15]), .TIMER_OUT_ONE_I(per[16]));
  sbpfs_pad_model u_pads (.clk_i(clk), .drv_i(po), .oe_i(poe), .ext_en_i(ee),
    .ext_val_i(ev), .pull_i(pull), .pad_o(pad));
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic fail(input string m);
    num_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) fail(m);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; wdat <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!(ack || err) && k < 20);
    if (k < 20) begin
      rq = dato;
      re = err;
      cyc <= 1'h0;
      stb <= 1'h0;
      @(posedge clk);
    end else begin
      fail("bus hang");
      wrap_up();
    end
  endtask
  function automatic void exp_pad(input int i, output logic o, output logic oe,
                                  output sbpfs_pull_e pl);
    logic [1:0] f, c;
    logic v, en;
    f = {fn[i+8], fn[i]};
    c = {dh[i], dl[i]};
    v = dat[i];
    en = 1'h1;
    if (f == 2'h1) {v, en} = (i == 5) ? {per[10], 1'h1} : {per[2*i], per[2*i+1]};
    else if (f != 2'h0) case (i)
      0: {v, en} = f[0] ? 2'h0 : {per[11], 1'h1};
      1: {v, en} = f[0] ? {per[14], 1'h1} : 2'h0;
      2: {v, en} = f[0] ? {per[15], 1'h1} : {per[12], per[13]};
      3: {v, en} = f[0] ? {per[16], 1'h1} : 2'h1;
      default: {v, en} = 2'h1;
    endcase
    pl = SBPFS_PULL_NONE;
    o = 1'h0;
    oe = 1'h0;
    if (dir[i]) pl = c == 2'h1 ? SBPFS_PULL_DOWN : c == 2'h2 ? SBPFS_PULL_UP : SBPFS_PULL_NONE;
    else begin
      oe = en & (c == 2'h3 || (c == 2'h1 && v) || (c == 2'h2 && !v));
      o = oe & (c == 2'h1 || (c == 2'h3 && v));
    end
  endfunction
  task automatic chk_pad(input int i);
    logic o, oe;
    sbpfs_pull_e pl;
    exp_pad(i, o, oe, pl);
    n_compared++;
    if ({po[i], poe[i]} !== {o, oe} || pull[i] !== pl) fail("pad state");
  endtask
  task automatic apply();
    wb(1'h1, `SBPFS_OFS_DATA, {26'h0, dat});
    wb(1'h1, `SBPFS_OFS_DIR, {26'h0, dir});
    wb(1'h1, `SBPFS_OFS_DRV_LOW, {26'h0, dl});
    wb(1'h1, `SBPFS_OFS_DRV_HIGH, {26'h0, dh});
    wb(1'h1, `SBPFS_OFS_FUNC, {16'h0, fn});
    repeat (3) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      chk_pad(i);
      mk[i] = !dir[i] || ee[i] || (dh[i] ^ dl[i]);
      lv[i] = !dir[i] ? dat[i] : ee[i] ? ev[i] : dh[i];
      // only input pins with a driver or pull settle to a known level
      pm[i] = dir[i] && (ee[i] || (dh[i] ^ dl[i]));
    end
    chk_reg({26'h0, plv & pm}, {26'h0, lv & pm}, "pin level");
    if (!(fn[8] && fn[0])) chk_reg({31'h0, ar}, 32'h1, "receive idle");
    else if (pm[0]) chk_reg({31'h0, ar}, {31'h0, lv[0]}, "receive level");
    wb(1'h0, `SBPFS_OFS_DATA, 32'h0);
    chk_reg(rq & {26'h0, mk}, {26'h0, lv & mk}, "data read");
    wb(1'h0, `SBPFS_OFS_FUNC, 32'h0);
    chk_reg(rq, {16'h0, fn}, "function read");
  endtask
  initial begin
    void'($urandom(10));
    {dat, dir, dl, dh, fn} = 40'h0;
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    apply();
    wb(1'h0, 8'h14, 32'h0);
    chk_reg({31'h0, re}, 32'h1, "unmapped error");
    chk_reg(rq, 32'h0, "unmapped data");
    // converter pins: high-z input with code 01, outside driver active
    dir = 6'h3F;
    fn = 16'h003F;
    ee <= 6'h3F;
    ev <= 6'h2A;
    apply();
    repeat (150) begin
      {dat, dir, dl, dh} = 24'($urandom);
      fn = 16'h3F3F & 16'($urandom);
      per <= 17'(($urandom));
      ee <= 6'($urandom);
      ev <= 6'($urandom);
      apply();
    end
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    {dat, dir, dl, dh, fn} = 40'h0;
    @(posedge clk);
    // reset alone must release every pin before any write
    for (int i = 0; i < 6; i++) chk_pad(i);
    apply();
    wrap_up();
  end
endmodule
